// >>> hw/hbp_host_port.sv
// Purpose: sram-like host bus port with data queue paths and irq
// Assumes: host pins synchronous to core_clk, one access per strobe
// Notes: csr bus is separate from the queue paths
`timescale 1ns/1ps
module hbp_host_port
  import hbp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [6:0] addr,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic chip_select_low,
  input wire logic queue_select,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_lo_oe,
  output logic data_hi_oe,
  output logic data_hi_pulldown_en,
  input wire logic bus_width_strap,
  output logic bus_is_32,
  input wire logic big_endian,
  input wire logic irq_active_high,
  input wire logic irq_open_drain,
  input wire logic [HBP_HOLD_W-1:0] irq_holdoff,
  input wire logic [HBP_SRC_N-1:0] irq_src_en,
  input wire logic [HBP_SRC_N-1:0] irq_events,
  output logic irq_out,
  output logic irq_oe,
  input wire logic low_power,
  output logic wake_pulse,
  output logic csr_rd,
  output logic csr_wr,
  output logic [HBP_CSR_AW-1:0] csr_addr,
  output logic [31:0] csr_wdata,
  input wire logic [31:0] csr_rdata,
  output logic [31:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [HBP_SIZE_W-1:0] tx_size_cfg,
  input wire logic [HBP_SIZE_W-1:0] rx_size_cfg,
  output logic [HBP_SIZE_W-1:0] tx_size,
  output logic [HBP_SIZE_W-1:0] rx_size,
  output logic tx_stall
);
  // ==========================================================
  // strap capture
  logic rst_d_reg;
  logic width32_reg;
  always_ff @(posedge core_clk) begin
    rst_d_reg <= rst;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      width32_reg <= 1'b0;
    end else if (rst_d_reg) begin
      width32_reg <= bus_width_strap;
    end
  end
  assign bus_is_32 = width32_reg;
  assign data_hi_pulldown_en = !width32_reg;
  // ==========================================================
  // strobe decode
  // chip select qualifies strobes
  wire sel = !chip_select_low;
  wire rd_req = sel && !read_strobe_low;
  wire wr_req = sel && !write_strobe_low;
  wire q_path = queue_select || (addr < HBP_CSR_BASE);
  wire q_is_tx = queue_select ? addr[HBP_QSEL_LSB] : (addr >= HBP_TX_DATA_ADDR);
  wire csr_hit = !queue_select && (addr >= HBP_CSR_BASE) && (addr <= HBP_CSR_LAST);
  // offsets outside both windows never reach mac buffers
  wire [6:0] csr_off = addr - HBP_CSR_BASE;
  // halfword select from address bit 1
  wire upper_half = addr[0];
  // ==========================================================
  // access sequencer: one action per strobe assertion
  hbp_state_t state_reg;
  hbp_state_t state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HBP_IDLE: begin
        if (rd_req) begin
          state_next = HBP_READ;
        end else if (wr_req) begin
          state_next = HBP_WRITE;
        end
      end
      HBP_READ: begin
        state_next = HBP_WAIT;
      end
      HBP_WRITE: begin
        state_next = HBP_WAIT;
      end
      HBP_WAIT: begin
        if (!rd_req && !wr_req) begin
          state_next = HBP_IDLE;
        end
      end
      default: begin
        state_next = HBP_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= HBP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // single action per strobe, no host wait states
  wire act_rd = (state_reg == HBP_READ);
  wire act_wr = (state_reg == HBP_WRITE);
  // ==========================================================
  // byte order
  // byte swap when big endian
  wire [31:0] din_ord = big_endian ? {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]} : data_in;
  wire [15:0] din_h = big_endian ? {data_in[7:0], data_in[15:8]} : data_in[15:0];
  // ==========================================================
  // write path and halfword assembly
  logic [15:0] lo_hold_reg;
  logic [31:0] csr_wdata_reg;
  logic csr_wr_reg;
  logic csr_rd_reg;
  logic [HBP_CSR_AW-1:0] csr_addr_reg;
  wire word_done = width32_reg || upper_half;
  // 16-bit halves join into 32-bit word
  wire [31:0] wr_word = width32_reg ? din_ord : {din_h, lo_hold_reg};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lo_hold_reg <= 16'h0000;
    end else if (act_wr && !width32_reg && !upper_half) begin
      lo_hold_reg <= din_h;
    end
  end
  // csr traffic on its own bus
  always_ff @(posedge core_clk) begin
    if (rst) begin
      csr_wr_reg <= 1'b0;
      csr_rd_reg <= 1'b0;
      csr_addr_reg <= '0;
      csr_wdata_reg <= 32'h0000_0000;
    end else begin
      csr_wr_reg <= act_wr && csr_hit && word_done;
      csr_rd_reg <= rd_req && (state_reg == HBP_IDLE) && csr_hit;
      csr_addr_reg <= csr_off[HBP_CSR_AW-1:0];
      csr_wdata_reg <= wr_word;
    end
  end
  assign csr_wr = csr_wr_reg;
  assign csr_rd = csr_rd_reg;
  assign csr_addr = csr_addr_reg;
  assign csr_wdata = csr_wdata_reg;
  // ==========================================================
  // transmit queue path through two-entry buffer
  hbp_stream_if tx_in ();
  hbp_stream_if tx_out ();
  // tx words queued on own path
  assign tx_in.valid = act_wr && q_path && q_is_tx && word_done;
  assign tx_in.data = wr_word;
  assign tx_stall = !tx_in.ready;
  hbp_buf2 u_tx_buf (
    .clk(core_clk),
    .rst(rst),
    .in_s(tx_in.snk),
    .out_s(tx_out.src)
  );
  assign tx_data = tx_out.data;
  assign tx_valid = tx_out.valid;
  assign tx_out.ready = tx_ready;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_size <= HBP_TX_SIZE_RST;
      rx_size <= HBP_RX_SIZE_RST;
    end else begin
      tx_size <= tx_size_cfg;
      rx_size <= rx_size_cfg;
    end
  end
  // ==========================================================
  // read path
  // rx data only from the rx queue
  wire rx_pop = act_rd && q_path && !q_is_tx && word_done;
  assign rx_ready = rx_pop;
  wire [31:0] rsrc = csr_hit ? csr_rdata : (rx_valid ? rx_data : 32'h0000_0000);
  wire [31:0] rsrc_ord = big_endian ? {rsrc[7:0], rsrc[15:8], rsrc[23:16], rsrc[31:24]} : rsrc;
  wire [15:0] rhalf = upper_half ? rsrc[31:16] : rsrc[15:0];
  wire [15:0] rhalf_ord = big_endian ? {rhalf[7:0], rhalf[15:8]} : rhalf;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_out <= 32'h0000_0000;
    end else if (act_rd) begin
      data_out <= width32_reg ? rsrc_ord : {16'h0000, rhalf_ord};
    end
  end
  wire reading = rd_req && (state_reg != HBP_IDLE);
  assign data_lo_oe = reading;
  assign data_hi_oe = reading && width32_reg;
  // ==========================================================
  // wake detect
  logic wake_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= low_power && wr_req && (state_reg == HBP_IDLE);
    end
  end
  assign wake_pulse = wake_reg;
  // ==========================================================
  // interrupt with hold-off; tick divider keeps counter short
  logic [HBP_TICK_W-1:0] tick_cnt_reg;
  logic [HBP_HOLD_W-1:0] hold_cnt_reg;
  logic irq_reg;
  wire tick = (tick_cnt_reg == HBP_TICK_W'(HBP_TICK_CYC - 1));
  wire irq_any = |(irq_events & irq_src_en);
  // restart the divider on a drop so the hold-off spans whole ticks
  wire irq_drop = irq_reg && !irq_any;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= (tick || irq_drop) ? '0 : tick_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
      hold_cnt_reg <= '0;
    end else if (irq_reg && !irq_any) begin
      irq_reg <= 1'b0;
      hold_cnt_reg <= irq_holdoff;
    end else if (hold_cnt_reg != '0) begin
      if (tick) begin
        hold_cnt_reg <= hold_cnt_reg - 1'b1;
      end
    end else begin
      irq_reg <= irq_any;
    end
  end
  assign irq_out = irq_open_drain ? 1'b0 : (irq_reg ~^ irq_active_high ? 1'b0 : 1'b1) ^ 1'b1;
  assign irq_oe = irq_open_drain ? irq_reg : 1'b1;
  // ==========================================================
  // checks
  // no action without select
  chk_cs_gates_action: assert property (@(posedge core_clk) disable iff (rst)
      (state_reg == HBP_IDLE && chip_select_low) |=> state_reg == HBP_IDLE)
    else $error("action without chip select");
  chk_read_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
      (state_reg == HBP_IDLE && rd_req) |=> act_rd ##1 !act_rd)
    else $error("read not single action");
  chk_write_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
      (state_reg == HBP_IDLE && !rd_req && wr_req) |=> act_wr ##1 !act_wr)
    else $error("write not single action");
  chk_wake_follows: assert property (@(posedge core_clk) disable iff (rst)
      (low_power && wr_req && state_reg == HBP_IDLE) |=> wake_pulse)
    else $error("wake missed");
  chk_qsel_no_csr: assert property (@(posedge core_clk) disable iff (rst)
      (act_wr && queue_select) |=> !csr_wr)
    else $error("queue access hit csr");
  chk_pulldown_mode: assert property (@(posedge core_clk) disable iff (rst)
      data_hi_pulldown_en == !bus_is_32)
    else $error("pull-down state wrong");
  chk_hi_lanes_idle: assert property (@(posedge core_clk) disable iff (rst)
      !bus_is_32 |-> !data_hi_oe)
    else $error("upper lanes driven in 16-bit");
  chk_strap_held: assert property (@(posedge core_clk) disable iff (rst)
      !rst_d_reg && !$past(rst_d_reg) |-> $stable(bus_is_32))
    else $error("width changed after reset");
  chk_irq_holdoff: assert property (@(posedge core_clk) disable iff (rst)
      $fell(irq_reg) && irq_holdoff != '0 |=> !irq_reg [*8])
    else $error("irq reasserted inside hold-off");
  chk_irq_masked: assert property (@(posedge core_clk) disable iff (rst)
      (irq_src_en == '0 && !irq_reg) |=> !irq_reg)
    else $error("masked source raised irq");
  cov_tx_word: cover property (@(posedge core_clk) disable iff (rst) tx_in.valid && tx_in.ready);
  cov_rx_pop: cover property (@(posedge core_clk) disable iff (rst) rx_pop && rx_valid);
  cov_tx_full: cover property (@(posedge core_clk) disable iff (rst) tx_stall);
  cov_wake: cover property (@(posedge core_clk) disable iff (rst) wake_pulse);
endmodule : hbp_host_port

// >>> hw/hbp_pkg.sv
// Purpose: shared constants and types for the host bus port
// Assumes: core_clk at 10 MHz, synchronous active-high reset
// Notes: word address map is local to this block
package hbp_pkg;
  // ==========================================================
  // address map (word addresses, a[7:1])
  localparam logic [6:0] HBP_RX_DATA_ADDR = 7'h00;
  localparam logic [6:0] HBP_TX_DATA_ADDR = 7'h10;
  localparam logic [6:0] HBP_CSR_BASE = 7'h20;
  localparam logic [6:0] HBP_CSR_LAST = 7'h7f;
  localparam int HBP_QSEL_LSB = 2;
  // ==========================================================
  // csr bus and queue widths
  localparam int HBP_CSR_AW = 7;
  localparam int HBP_DW = 32;
  localparam int HBP_HW = 16;
  localparam int HBP_SIZE_W = 4;
  localparam logic [HBP_SIZE_W-1:0] HBP_TX_SIZE_RST = 4'h8;
  localparam logic [HBP_SIZE_W-1:0] HBP_RX_SIZE_RST = 4'h8;
  // ==========================================================
  // interrupt hold-off: one tick per 10 us at 10 MHz
  localparam int HBP_CLK_MHZ = 10;
  localparam int HBP_TICK_US = 10;
  localparam int HBP_TICK_CYC = HBP_TICK_US * HBP_CLK_MHZ;
  localparam int HBP_TICK_W = 7;
  localparam int HBP_HOLD_W = 8;
  localparam int HBP_SRC_N = 8;
  // ==========================================================
  // buffer depth
  localparam int HBP_BUF_DEPTH = 2;
  typedef enum logic [1:0] {HBP_IDLE, HBP_READ, HBP_WRITE, HBP_WAIT} hbp_state_t;
endpackage : hbp_pkg

// >>> hw/hbp_stream_if.sv
// Purpose: valid/ready word stream between port modules
// Assumes: single clock domain
// Notes: source drives data and valid, sink drives ready
`timescale 1ns/1ps
interface hbp_stream_if;
  logic [31:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : hbp_stream_if

// >>> hw/hbp_buf2.sv
// Purpose: two-entry skid buffer on the word path
// Assumes: synchronous reset
// Notes: ready follows free space, so a stalled sink fills it
`timescale 1ns/1ps
module hbp_buf2
  import hbp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  hbp_stream_if.snk in_s,
  hbp_stream_if.src out_s
);
  // ==========================================================
  // storage
  logic [HBP_DW-1:0] mem_reg [HBP_BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;
  assign in_s.ready = (cnt_reg != 2'h2);
  assign out_s.valid = (cnt_reg != 2'h0);
  assign out_s.data = mem_reg[rd_ptr_reg];
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  chk_buf_no_overfill: assert property (@(posedge clk) disable iff (rst) cnt_reg <= 2'h2)
    else $error("buffer count above two");
  chk_buf_full_stall: assert property (@(posedge clk) disable iff (rst) (cnt_reg == 2'h2) |-> !in_s.ready)
    else $error("buffer full yet ready");
  cov_buf_fill: cover property (@(posedge clk) disable iff (rst) cnt_reg == 2'h2);
endmodule : hbp_buf2

// >>> verif/hbp_mac_model.sv
// Purpose: behavioural mac side of the host bus port
// Assumes: one clock, rx source never runs dry
// Notes: stall holds tx_ready low so the word buffer fills
`timescale 1ns/1ps
module hbp_mac_model
  import hbp_pkg::*;
#(
  parameter logic [31:0] RX_BASE = 32'h1234_0000,
  parameter logic [31:0] CSR_VAL = 32'hc3a5_0f96
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stall,
  output logic tx_ready,
  output logic [31:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [31:0] csr_rdata
);
  logic [31:0] rx_cnt_reg;
  // ==========
  // queue paths
  // separate tx sink, stalls on demand
  assign tx_ready = !stall;
  assign rx_valid = !rst;
  // no stale word when idle: show the inverse
  assign rx_data = rx_valid ? RX_BASE + rx_cnt_reg : ~(RX_BASE + rx_cnt_reg);
  // csr bus answers apart from queues
  assign csr_rdata = CSR_VAL;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_cnt_reg <= 32'h0;
    end else if (rx_valid && rx_ready) begin
      rx_cnt_reg <= rx_cnt_reg + 32'h1;
    end
  end
endmodule : hbp_mac_model

// >>> verif/test_sram_like_host_bus_port.sv
// Purpose: self-checking bench for the host bus port
// Assumes: host strobes driven on core_clk edges
// Notes: tx and csr writes are scored from a queue of notes
`timescale 1ns/1ps
module test_sram_like_host_bus_port
  import hbp_pkg::*;
;
  localparam logic [31:0] RX_BASE = 32'h1234_0000;
  localparam logic [31:0] CSR_VAL = 32'hc3a5_0f96;
  logic core_clk, rst, read_strobe_low, write_strobe_low, chip_select_low, queue_select;
  logic [6:0] addr;
  logic [31:0] data_in, data_out, csr_wdata, csr_rdata, tx_data, rx_data;
  logic data_lo_oe, data_hi_oe, data_hi_pulldown_en, bus_width_strap, bus_is_32, big_endian;
  logic irq_active_high, irq_open_drain, irq_out, irq_oe, low_power, wake_pulse, stall;
  logic [HBP_HOLD_W-1:0] irq_holdoff;
  logic [HBP_SRC_N-1:0] irq_src_en, irq_events;
  logic csr_rd, csr_wr, tx_valid, tx_ready, rx_valid, rx_ready, tx_stall;
  logic [HBP_CSR_AW-1:0] csr_addr;
  logic [HBP_SIZE_W-1:0] tx_size_cfg, rx_size_cfg, tx_size, rx_size;
  logic [39:0] exp_q[$];
  logic [31:0] rs, q, d, e, w;
  logic lo, hi;
  int fail_count, n_checks, cyc, wake_n, pops, n;

  hbp_host_port hbp_host_port_i (.core_clk(core_clk), .rst(rst), .addr(addr),
    .read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
    .chip_select_low(chip_select_low), .queue_select(queue_select), .data_in(data_in),
    .data_out(data_out), .data_lo_oe(data_lo_oe), .data_hi_oe(data_hi_oe),
    .data_hi_pulldown_en(data_hi_pulldown_en), .bus_width_strap(bus_width_strap),
    .bus_is_32(bus_is_32), .big_endian(big_endian), .irq_active_high(irq_active_high),
    .irq_open_drain(irq_open_drain), .irq_holdoff(irq_holdoff), .irq_src_en(irq_src_en),
    .irq_events(irq_events), .irq_out(irq_out), .irq_oe(irq_oe), .low_power(low_power),
    .wake_pulse(wake_pulse), .csr_rd(csr_rd), .csr_wr(csr_wr), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_size_cfg(tx_size_cfg), .rx_size_cfg(rx_size_cfg), .tx_size(tx_size),
    .rx_size(rx_size), .tx_stall(tx_stall));
  hbp_mac_model #(.RX_BASE(RX_BASE), .CSR_VAL(CSR_VAL)) hbp_mac_model_i (.core_clk(core_clk),
    .rst(rst), .stall(stall), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .csr_rdata(csr_rdata));

  // ==========
  // helpers
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  function automatic logic [31:0] bswap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : bswap

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic see(input logic [39:0] v);
    if (exp_q.size() == 0) begin
      chk(v, 40'hff_ffff_ffff);
    end else begin
      chk(v, exp_q.pop_front());
    end
  endtask : see

  // one host access; strobes held until data_out has settled
  task automatic acc(input logic wr, input logic [6:0] a, input logic qs, input logic [31:0] v,
    input logic csn);
    @(posedge core_clk);
    addr <= a;
    queue_select <= qs;
    data_in <= v;
    chip_select_low <= csn;
    read_strobe_low <= wr;
    write_strobe_low <= !wr;
    repeat (4) @(posedge core_clk);
    #1;
    q = data_out;
    lo = data_lo_oe;
    hi = data_hi_oe;
    @(posedge core_clk);
    read_strobe_low <= 1'b1;
    write_strobe_low <= 1'b1;
    chip_select_low <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({lo, hi, data_lo_oe, data_hi_oe}, {!wr && !csn, !wr && !csn && bus_is_32, 2'b00});
  endtask : acc

  task automatic do_reset(input logic strap);
    @(posedge core_clk);
    rst <= 1'b1;
    bus_width_strap <= strap;
    repeat (10) @(posedge core_clk);
    #1;
    chk({tx_size, rx_size}, {HBP_TX_SIZE_RST, HBP_RX_SIZE_RST});
    @(posedge core_clk);
    rst <= 1'b0;
    pops = 0;
    repeat (3) @(posedge core_clk);
    #1;
    chk({bus_is_32, data_hi_pulldown_en, tx_size, rx_size}, {strap, !strap, 8'h35});
    @(posedge core_clk);
    bus_width_strap <= !strap;
    repeat (2) @(posedge core_clk);
    #1;
    chk(bus_is_32, strap);
  endtask : do_reset

  task automatic irq_is(input logic a);
    #1;
    chk({irq_oe, irq_out}, irq_open_drain ? {a, 1'b0} : {1'b1, a ~^ irq_active_high});
  endtask : irq_is

  // ==========
  // clock, scoreboard and timeout
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = !core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (!rst && tx_valid && tx_ready) see({8'h40, tx_data});
    if (!rst && csr_wr) see({1'b1, csr_addr, csr_wdata});
    if (!rst && csr_rd) see({8'h20, 25'h0, csr_addr});
    if (!rst && wake_pulse) wake_n++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========
  // main sequence
  initial begin
    rs = 32'd65456;
    {rst, read_strobe_low, write_strobe_low, chip_select_low} = 4'hf;
    {queue_select, big_endian, irq_active_high, irq_open_drain, low_power, stall} = 6'h0;
    {addr, data_in, bus_width_strap, irq_holdoff} = '0;
    {irq_src_en, irq_events, tx_size_cfg, rx_size_cfg} = 24'h0000_35;
    do_reset(1'b1);
    d = rnd();
    exp_q.push_back({1'b1, 7'h00, d});
    acc(1'b1, 7'h20, 1'b0, d, 1'b0);
    d = rnd();
    exp_q.push_back({1'b1, 7'h5f, d});
    acc(1'b1, 7'h7f, 1'b0, d, 1'b0);
    acc(1'b1, 7'h25, 1'b0, rnd(), 1'b1);
    acc(1'b0, 7'h00, 1'b0, rnd(), 1'b1);
    exp_q.push_back({8'h20, 25'h0, 7'h0a});
    acc(1'b0, 7'h2a, 1'b0, rnd(), 1'b0);
    chk(q, CSR_VAL);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      big_endian <= i[1];
      d = rnd();
      exp_q.push_back({8'h40, i[1] ? bswap(d) : d});
      acc(1'b1, i[0] ? 7'h7c : 7'h1f, i[0], d, 1'b0);
      acc(1'b0, i[0] ? 7'h7b : 7'h03, i[0], rnd(), 1'b0);
      w = RX_BASE + pops;
      chk(q, i[1] ? bswap(w) : w);
      pops++;
    end
    @(posedge core_clk);
    stall <= 1'b1;
    big_endian <= 1'b0;
    n = 0;
    while (tx_stall !== 1'b1 && n < 4) begin
      d = rnd();
      exp_q.push_back({8'h40, d});
      acc(1'b1, 7'h10, 1'b0, d, 1'b0);
      n++;
    end
    chk(n, HBP_BUF_DEPTH);
    acc(1'b1, 7'h10, 1'b0, rnd(), 1'b0);
    @(posedge core_clk);
    stall <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(wake_n, 0);
    @(posedge core_clk);
    low_power <= 1'b1;
    d = rnd();
    exp_q.push_back({1'b1, 7'h01, d});
    acc(1'b1, 7'h21, 1'b0, d, 1'b0);
    chk(wake_n, 1);
    @(posedge core_clk);
    low_power <= 1'b0;
    irq_src_en <= 8'h08;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      {irq_open_drain, irq_active_high} <= i[1:0];
      irq_events <= 8'h20;
      repeat (4) @(posedge core_clk);
      irq_is(1'b0);
      @(posedge core_clk);
      irq_events <= 8'h28;
      repeat (4) @(posedge core_clk);
      irq_is(1'b1);
      @(posedge core_clk);
      irq_events <= 8'h20;
      repeat (4) @(posedge core_clk);
      irq_is(1'b0);
    end
    @(posedge core_clk);
    {irq_open_drain, irq_active_high, irq_holdoff} <= 10'h102;
    irq_events <= 8'h28;
    repeat (4) @(posedge core_clk);
    irq_is(1'b1);
    @(posedge core_clk);
    irq_events <= 8'h20;
    repeat (4) @(posedge core_clk);
    irq_is(1'b0);
    @(posedge core_clk);
    irq_events <= 8'h28;
    repeat (50) @(posedge core_clk);
    irq_is(1'b0);
    repeat (250) @(posedge core_clk);
    irq_is(1'b1);
    do_reset(1'b0);
    d = rnd();
    e = rnd();
    exp_q.push_back({8'h40, d});
    acc(1'b1, 7'h10, 1'b0, {e[31:16], d[15:0]}, 1'b0);
    acc(1'b1, 7'h11, 1'b0, {e[15:0], d[31:16]}, 1'b0);
    acc(1'b0, 7'h00, 1'b0, rnd(), 1'b0);
    chk(q[15:0], RX_BASE[15:0]);
    acc(1'b0, 7'h01, 1'b0, rnd(), 1'b0);
    chk(q[15:0], RX_BASE[31:16]);
    acc(1'b0, 7'h00, 1'b0, rnd(), 1'b0);
    w = RX_BASE + 32'h1;
    chk(q[15:0], w[15:0]);
    repeat (10) @(posedge core_clk);
    chk(exp_q.size(), 0);
    test_done();
  end
endmodule : test_sram_like_host_bus_port
